// >>> inc/fp_format_cfg.svh
`ifndef FP_FORMAT_CFG_SVH
`define FP_FORMAT_CFG_SVH

// ----------------------------------------------------------------------
// Format geometry
// ----------------------------------------------------------------------
`define SGL_WIDTH      32
`define SGL_PREC       24
`define SGL_EXP_W      8
`define SGL_FRAC_W     23
`define SGL_BIAS       127
`define SGL_SIGN_BIT   31
`define SGL_EXP_HI     30
`define SGL_EXP_LO     23
`define SGL_FRAC_HI    22
`define DBL_WIDTH      64
`define DBL_PREC       53
`define DBL_EXP_W      11
`define DBL_FRAC_W     52
`define DBL_BIAS       1023
`define DBL_SIGN_BIT   63
`define DBL_EXP_HI     62
`define DBL_EXP_LO     52
`define DBL_FRAC_HI    51

// ----------------------------------------------------------------------
// Default quiet NaN patterns, legacy and new encoding
// ----------------------------------------------------------------------
`define SGL_QUIET_NAN_LEGACY 32'h7fbfffff
`define SGL_QUIET_NAN_NEW    32'h7fffffff
`define DBL_QUIET_NAN_LEGACY 64'h7ff7ffffffffffff
`define DBL_QUIET_NAN_NEW    64'h7fffffffffffffff

// ----------------------------------------------------------------------
// Control/status word field positions
// ----------------------------------------------------------------------
`define CSR_WIDTH      32
`define CSR_FTZ_BIT    24
`define CSR_NANSEL_BIT 18
`define CSR_CC_BIT     23
`define CSR_CAUSE_UNIMP 17
`define CSR_CAUSE_INV  16
`define CSR_FLAG_INV   6
`define CSR_RESET      32'h00000000
`define CSR_WMASK      32'h0184007c

`endif

// >>> inc/fp_format_pkg.sv
`default_nettype none
package fp_format_pkg;
  // Operation codes presented on the coprocessor interface
  typedef enum logic [2:0] {
    OP_CLASSIFY = 3'b000,
    OP_MOVE     = 3'b001,
    OP_ABS      = 3'b010,
    OP_NEG      = 3'b011,
    OP_INVALID  = 3'b100,
    OP_CTC      = 3'b101,
    OP_CFC      = 3'b110,
    OP_CMP_EQ   = 3'b111
  } fp_op_t;

  // Operand class codes
  typedef enum logic [2:0] {
    CLS_ZERO      = 3'b000,
    CLS_NORMAL    = 3'b001,
    CLS_DENORMAL  = 3'b010,
    CLS_INFINITY  = 3'b011,
    CLS_SIG_NAN   = 3'b100,
    CLS_QUIET_NAN = 3'b101
  } fp_class_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_DONE  = 2'b10
  } fp_state_t;
endpackage
`default_nettype wire

// >>> logic/fp_format_unit.sv
`include "fp_format_cfg.svh"
`default_nettype none

// What this block does
// RQ1: Single carries 24-bit significand, double 53-bit, hidden bit counted.
// RQ2: Exponent field is 8 bits single and 11 bits double.
// RQ3: Fraction field is 23 bits single, 52 double; words 32 and 64.
// RQ4: Stored exponent is true exponent plus bias 127 or 1023.
// RQ5: Double word: sign bit 63, exponent 62..52, fraction 51..0.
// RQ6: Leading significand bit is implicit, fraction holds bits after point.
// RQ7: Max exponent, nonzero fraction is NaN; top bit sense set by select.
// RQ8: Denormal operands or results trap to software instead of computing.
// RQ9: Flush-to-zero mode in control word replaces denormals by zero.
// RQ10: Exceptions are precise; faulting op changes no state. A faulting op here still sets cause bit 17 and clears cause bit 16.
// RQ11: Busy interlock holds new requests until the result is out.
// RQ12: A 32-bit control/status word controls unit and records conditions.
// RQ13: Datapath and register path are full 64 bits wide.
// RQ14: Reciprocal ops would use relaxed precision; none in this front end.
// RQ15: Compound multiply-add must match separate ops; none in this front end.
// RQ16: Fixed-point data are signed two's complement integers only.
// RQ17: Host reaches the unit only through this coprocessor interface.
// RQ18: Untrapped invalid op yields default quiet NaN chosen by select.
// RQ19: Single word: sign bit 31, exponent 30..23, fraction 22..0.
// RQ20: Max exponent with zero fraction is infinity signed by sign bit.
module fp_format_unit (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        REQ_VALID_I,
  input  wire logic [2:0]  REQ_OP_I,
  input  wire logic        REQ_DBL_I,
  input  wire logic [63:0] REQ_A_I,
  input  wire logic [63:0] REQ_B_I,
  output logic             REQ_READY_O,
  output logic             RSP_VALID_O,
  output logic [63:0]      RSP_DATA_O,
  output logic [2:0]       RSP_CLASS_O,
  output logic             RSP_EXC_O,
  output logic [31:0]      CSR_O
);

  // ----------------------------------------------------------------------
  // Operand fields
  // ----------------------------------------------------------------------
  fp_format_pkg::fp_state_t state_q;
  fp_format_pkg::fp_op_t    op_q;
  logic                     dbl_q;
  logic [63:0]              a_q;
  logic [63:0]              b_q;
  logic [31:0]              csr_q;
  logic                     ftz;
  logic                     nan_sel;

  assign ftz     = csr_q[`CSR_FTZ_BIT];    // [RQ9]
  assign nan_sel = csr_q[`CSR_NANSEL_BIT]; // [RQ7]

  // Significand with the hidden bit made explicit; only the exponent implies it, it is never stored
  logic [`SGL_PREC-1:0]     sig_s;
  logic [`DBL_PREC-1:0]     sig_d;
  assign sig_s = {|a_q[`SGL_EXP_HI:`SGL_EXP_LO], a_q[`SGL_FRAC_HI:0]}; // [RQ1] [RQ6]
  assign sig_d = {|a_q[`DBL_EXP_HI:`DBL_EXP_LO], a_q[`DBL_FRAC_HI:0]}; // [RQ1] [RQ6]

  // Field extraction for one operand, both formats
  function automatic fp_format_pkg::fp_class_t classify(input logic [63:0] w, input logic d, input logic ns);
    logic                   exp_max;
    logic                   exp_zero;
    logic                   frac_nz;
    logic                   top;
    logic [`SGL_EXP_W-1:0]  es;
    logic [`DBL_EXP_W-1:0]  ed;
    es = w[`SGL_EXP_HI:`SGL_EXP_LO];                           // [RQ19] [RQ2]
    ed = w[`DBL_EXP_HI:`DBL_EXP_LO];                           // [RQ5] [RQ2]
    if (d) begin
      exp_max  = &ed;
      exp_zero = ~|ed;
      frac_nz  = |w[`DBL_FRAC_HI:0];                           // [RQ3] [RQ6]
      top      = w[`DBL_FRAC_HI];
    end else begin
      exp_max  = &es;
      exp_zero = ~|es;
      frac_nz  = |w[`SGL_FRAC_HI:0];                           // [RQ3] [RQ6]
      top      = w[`SGL_FRAC_HI];
    end
    if (exp_max && !frac_nz) begin
      classify = fp_format_pkg::CLS_INFINITY;                  // [RQ20]
    end else if (exp_max) begin
      classify = (top ^ ns) ? fp_format_pkg::CLS_SIG_NAN : fp_format_pkg::CLS_QUIET_NAN; // [RQ7]
    end else if (exp_zero && frac_nz) begin
      classify = fp_format_pkg::CLS_DENORMAL;
    end else if (exp_zero) begin
      classify = fp_format_pkg::CLS_ZERO;
    end else begin
      classify = fp_format_pkg::CLS_NORMAL;                    // [RQ4]
    end
  endfunction

  // Flush a denormal to a signed zero of the same format
  function automatic logic [63:0] flush(input logic [63:0] w, input logic d);
    if (d) begin
      flush = {w[`DBL_SIGN_BIT], 63'h0};
    end else begin
      flush = {32'h0, w[`SGL_SIGN_BIT], 31'h0};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Combinational result of the held operation
  // ----------------------------------------------------------------------
  fp_format_pkg::fp_class_t cls_a;
  fp_format_pkg::fp_class_t cls_b;
  logic [63:0]              a_eff;
  logic [63:0]              b_eff;
  logic [63:0]              res_d;
  logic                     unimp_d;
  logic                     inv_d;
  logic                     cc_d;
  logic [63:0]              sign_mask;

  assign cls_a     = classify(a_q, dbl_q, nan_sel);
  assign cls_b     = classify(b_q, dbl_q, nan_sel);
  assign sign_mask = dbl_q ? 64'h8000000000000000 : 64'h0000000080000000;

  // Denormal inputs to classify, abs, neg and compare either flush to zero or raise an unimplemented trap
  always_comb begin
    a_eff   = a_q;
    b_eff   = b_q;
    unimp_d = 1'b0;
    inv_d   = 1'b0;
    cc_d    = csr_q[`CSR_CC_BIT];
    res_d   = a_q;
    if (cls_a == fp_format_pkg::CLS_DENORMAL) begin
      if (ftz) a_eff = flush(a_q, dbl_q);                      // [RQ9]
      else unimp_d = 1'b1;                                     // [RQ8]
    end
    if (cls_b == fp_format_pkg::CLS_DENORMAL && op_q == fp_format_pkg::OP_CMP_EQ) begin
      if (ftz) b_eff = flush(b_q, dbl_q);                      // [RQ9]
      else unimp_d = 1'b1;                                     // [RQ8]
    end
    // Only exact sign, move, format and compare ops are decoded: no reciprocal estimates here [RQ14]
    // No fused multiply-add either, so no rounding can differ from separate ops [RQ15]
    unique case (op_q)
      fp_format_pkg::OP_CLASSIFY: res_d = a_eff;
      // Moves are non-arithmetic, so they never signal or trap
      fp_format_pkg::OP_MOVE: begin
        res_d   = a_q;
        unimp_d = 1'b0;
      end
      fp_format_pkg::OP_ABS:      res_d = a_eff & ~sign_mask;
      fp_format_pkg::OP_NEG:      res_d = a_eff ^ sign_mask;
      fp_format_pkg::OP_INVALID: begin
        // Quiet NaN input propagates, else a fresh default quiet NaN
        if (cls_a == fp_format_pkg::CLS_QUIET_NAN) res_d = a_q;
        else if (dbl_q) res_d = nan_sel ? `DBL_QUIET_NAN_NEW : `DBL_QUIET_NAN_LEGACY;       // [RQ18]
        else res_d = {32'h0, nan_sel ? `SGL_QUIET_NAN_NEW : `SGL_QUIET_NAN_LEGACY};        // [RQ18]
        inv_d   = cls_a != fp_format_pkg::CLS_QUIET_NAN;
        unimp_d = 1'b0;
      end
      fp_format_pkg::OP_CTC: begin
        res_d   = {32'h0, (csr_q & ~`CSR_WMASK) | (a_q[31:0] & `CSR_WMASK)};
        unimp_d = 1'b0;
      end
      fp_format_pkg::OP_CFC: begin
        res_d   = {32'h0, csr_q};
        unimp_d = 1'b0;
      end
      fp_format_pkg::OP_CMP_EQ: begin
        // Floating-point equality: NaNs compare unequal, zeros of either sign compare equal
        res_d = 64'h0;
        if (cls_a == fp_format_pkg::CLS_SIG_NAN || cls_b == fp_format_pkg::CLS_SIG_NAN) begin
          inv_d = 1'b1;
        end
        if (cls_a == fp_format_pkg::CLS_SIG_NAN || cls_a == fp_format_pkg::CLS_QUIET_NAN ||
            cls_b == fp_format_pkg::CLS_SIG_NAN || cls_b == fp_format_pkg::CLS_QUIET_NAN) begin
          cc_d = 1'b0;
        end else begin
          cc_d = ((a_eff | sign_mask) == (b_eff | sign_mask)) &&
                 ((a_eff == b_eff) || (((a_eff & ~sign_mask) | (b_eff & ~sign_mask)) == 64'h0));
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer: one request in flight, host held off while busy
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= fp_format_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        fp_format_pkg::ST_IDLE: if (REQ_VALID_I && REQ_READY_O) state_q <= fp_format_pkg::ST_EXEC; // [RQ11]
        fp_format_pkg::ST_EXEC: state_q <= fp_format_pkg::ST_DONE;
        fp_format_pkg::ST_DONE: state_q <= fp_format_pkg::ST_IDLE;
        default:                state_q <= fp_format_pkg::ST_IDLE;
      endcase
    end
  end

  // Ready is low from acceptance until the answer has been shown
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      REQ_READY_O <= 1'b0;
    end else begin
      REQ_READY_O <= (state_q == fp_format_pkg::ST_DONE) ||
                     (state_q == fp_format_pkg::ST_IDLE && !(REQ_VALID_I && REQ_READY_O)); // [RQ11]
    end
  end

  // Operand capture, full 64-bit path
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_q  <= fp_format_pkg::OP_CLASSIFY;
      dbl_q <= 1'b0;
      a_q   <= 64'h0;
      b_q   <= 64'h0;
    end else if (state_q == fp_format_pkg::ST_IDLE && REQ_VALID_I && REQ_READY_O) begin
      op_q  <= fp_format_pkg::fp_op_t'(REQ_OP_I);
      dbl_q <= REQ_DBL_I;
      a_q   <= REQ_A_I;                                        // [RQ13] [RQ16]
      b_q   <= REQ_B_I;
    end
  end

  // ----------------------------------------------------------------------
  // Control/status word: trap leaves condition bit and flags untouched
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      csr_q <= `CSR_RESET;
    end else if (state_q == fp_format_pkg::ST_EXEC) begin
      csr_q[`CSR_CAUSE_UNIMP] <= unimp_d;                      // [RQ12]
      csr_q[`CSR_CAUSE_INV]   <= inv_d && !unimp_d;
      if (!unimp_d) begin                                      // [RQ10]
        if (op_q == fp_format_pkg::OP_CTC) begin
          csr_q <= res_d[31:0];
        end else begin
          csr_q[`CSR_CC_BIT] <= cc_d;
          if (inv_d) csr_q[`CSR_FLAG_INV] <= 1'b1;
        end
      end
    end
  end

  // Answer registers, shown for one cycle
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O  <= 64'h0;
      RSP_CLASS_O <= 3'h0;
      RSP_EXC_O   <= 1'b0;
    end else begin
      RSP_VALID_O <= state_q == fp_format_pkg::ST_EXEC;
      RSP_EXC_O   <= state_q == fp_format_pkg::ST_EXEC && unimp_d;
      if (state_q == fp_format_pkg::ST_EXEC) begin
        RSP_DATA_O  <= unimp_d ? 64'h0 : res_d;                // [RQ10]
        RSP_CLASS_O <= cls_a;
      end
    end
  end

  // Status word mirror
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) CSR_O <= `CSR_RESET;
    else CSR_O <= csr_q;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_busy_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q != fp_format_pkg::ST_IDLE) |-> !REQ_READY_O) else $error("ready while busy"); // [RQ11]
  a_rsp_timing: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (REQ_VALID_I && REQ_READY_O) |-> ##2 RSP_VALID_O) else $error("answer late"); // [RQ11]
  a_inf_class: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == fp_format_pkg::ST_EXEC && dbl_q && &a_q[62:52] && a_q[51:0] == 52'h0)
    |=> RSP_CLASS_O == fp_format_pkg::CLS_INFINITY) else $error("inf class"); // [RQ20]
  a_nan_sense: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == fp_format_pkg::ST_EXEC && !dbl_q && &a_q[30:23] && a_q[22] && |a_q[22:0])
    |=> RSP_CLASS_O == (nan_sel ? fp_format_pkg::CLS_QUIET_NAN : fp_format_pkg::CLS_SIG_NAN))
    else $error("nan sense"); // [RQ7]
  a_dflt_nan: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == fp_format_pkg::ST_EXEC && op_q == fp_format_pkg::OP_INVALID && !dbl_q &&
     cls_a != fp_format_pkg::CLS_QUIET_NAN)
    |=> RSP_DATA_O[31:0] == ($past(nan_sel) ? 32'h7fffffff : 32'h7fbfffff)) else $error("default nan"); // [RQ18]
  a_denorm_trap: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == fp_format_pkg::ST_EXEC && op_q == fp_format_pkg::OP_ABS && !ftz &&
     cls_a == fp_format_pkg::CLS_DENORMAL) |=> RSP_EXC_O) else $error("no trap"); // [RQ8]
  a_ftz_zero: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == fp_format_pkg::ST_EXEC && op_q == fp_format_pkg::OP_ABS && ftz && dbl_q &&
     cls_a == fp_format_pkg::CLS_DENORMAL) |=> !RSP_EXC_O && RSP_DATA_O == 64'h0) else $error("ftz"); // [RQ9]
  a_precise_exc: assert property (@(posedge MCLK_I) disable iff (RST_I)
    RSP_EXC_O |-> RSP_DATA_O == 64'h0 && $stable(CSR_O[6])) else $error("imprecise"); // [RQ10]
  a_exc_pulse: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ10]
    RSP_EXC_O |-> RSP_VALID_O) else $error("trap without answer");
  a_hidden_bit: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ1]
    (cls_a == fp_format_pkg::CLS_NORMAL) |->
    (dbl_q ? sig_d[`DBL_PREC-1] : sig_s[`SGL_PREC-1])) else $error("hidden bit");
  a_cmp_nan: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ7]
    (state_q == fp_format_pkg::ST_EXEC && op_q == fp_format_pkg::OP_CMP_EQ && !unimp_d &&
     (cls_a == fp_format_pkg::CLS_QUIET_NAN || cls_a == fp_format_pkg::CLS_SIG_NAN))
    |=> !csr_q[`CSR_CC_BIT]) else $error("nan compare");
  c_trap: cover property (@(posedge MCLK_I) disable iff (RST_I) RSP_EXC_O);
  c_ftz: cover property (@(posedge MCLK_I) disable iff (RST_I) RSP_VALID_O && CSR_O[24]);
  c_b2b: cover property (@(posedge MCLK_I) disable iff (RST_I) RSP_VALID_O ##2 RSP_VALID_O);
  c_quiet_nan: cover property (@(posedge MCLK_I) disable iff (RST_I)
    RSP_VALID_O && RSP_CLASS_O == fp_format_pkg::CLS_QUIET_NAN);

endmodule
`default_nettype wire

// >>> tb/host_core_model.sv
`default_nettype none
// ----------------------------------------
// Host core side of the coprocessor link
// ----------------------------------------
module host_core_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [2:0]       op_o,
  output logic             dbl_o,
  output logic [63:0]      a_o,
  output logic [63:0]      b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values from time zero
  initial begin
    valid_o = 1'b0;
    op_o = 3'h0;
    dbl_o = 1'b0;
    a_o = 64'h0;
    b_o = 64'h0;
  end

  // One transfer, held until the edge that sees ready high
  task automatic issue(input logic [2:0] op, input logic dbl, input logic [63:0] a, input logic [63:0] b,
                       output logic taken);
    int n;
    @(posedge clk_i);
    valid_o <= 1'b1;
    op_o <= op;
    dbl_o <= dbl;
    a_o <= a;
    b_o <= b;
    taken = 1'b0;
    for (n = 0; n < 20 && !taken; n++) begin
      @(posedge clk_i);
      taken = (ready_i === 1'b1);
    end
    // Released operands flip so a stale value is never mistaken for live data
    valid_o <= 1'b0;
    a_o <= ~a;
    b_o <= ~b;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`include "fp_format_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [63:0] d; logic [63:0] m; logic [2:0] c; logic cm; logic x; logic xm; int t;} exp_t;
  localparam logic [63:0] M32 = 64'h00000000ffffffff;
  localparam logic [63:0] ALL = 64'hffffffffffffffff;
  logic        clk;
  logic        rst;
  logic        req_valid;
  logic [2:0]  req_op;
  logic        req_dbl;
  logic [63:0] req_a;
  logic [63:0] req_b;
  logic        req_ready;
  logic        rsp_valid;
  logic [63:0] rsp_data;
  logic [2:0]  rsp_class;
  logic        rsp_exc;
  logic [31:0] csr;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] csr_m = 32'h0;
  exp_t        exp_q[$];
  exp_t        cur;
  logic [31:0] pat_s [8] = '{32'h0, 32'h80000000, 32'h00800000, 32'h007fffff, 32'h7f800000, 32'hff800000,
                             32'h7fffffff, 32'h7fbfffff};
  logic [63:0] pat_d [8] = '{64'h0, 64'h8000000000000000, 64'h3ff0000000000000, 64'h000fffffffffffff,
                             64'h7ff0000000000000, 64'hfff0000000000000, 64'h7fffffffffffffff, 64'h7ff7ffffffffffff};
  logic [63:0] qn [4] = '{{32'h0, `SGL_QUIET_NAN_LEGACY}, {32'h0, `SGL_QUIET_NAN_NEW}, `DBL_QUIET_NAN_LEGACY, `DBL_QUIET_NAN_NEW};
  logic [2:0]  sgn_ops [3] = '{fp_format_pkg::OP_MOVE, fp_format_pkg::OP_ABS, fp_format_pkg::OP_NEG};

  fp_format_unit dut (.MCLK_I(clk), .RST_I(rst), .REQ_VALID_I(req_valid), .REQ_OP_I(req_op), .REQ_DBL_I(req_dbl),
    .REQ_A_I(req_a), .REQ_B_I(req_b), .REQ_READY_O(req_ready), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
    .RSP_CLASS_O(rsp_class), .RSP_EXC_O(rsp_exc), .CSR_O(csr));
  host_core_model host (.clk_i(clk), .ready_i(req_ready), .valid_o(req_valid), .op_o(req_op), .dbl_o(req_dbl),
    .a_o(req_a), .b_o(req_b));

  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Compare and bookkeeping tasks
  // ----------------------------------------
  task automatic chk_val(input string what, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cls(input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value class expected %0d seen %0d", e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Expected class from the field layout; NaN sense follows the select bit
  function automatic logic [2:0] cls_of(input logic dbl, input logic [63:0] a);
    logic [10:0] e;
    logic [51:0] f;
    logic        top;
    e = dbl ? a[62:52] : {3'h0, a[30:23]};
    f = dbl ? a[51:0] : {29'h0, a[22:0]};
    top = dbl ? a[51] : a[22];
    if (e == 11'h0) return (f == 52'h0) ? fp_format_pkg::CLS_ZERO : fp_format_pkg::CLS_DENORMAL;
    if (e != (dbl ? 11'h7ff : 11'h0ff)) return fp_format_pkg::CLS_NORMAL;
    if (f == 52'h0) return fp_format_pkg::CLS_INFINITY;
    return (top ^ csr_m[`CSR_NANSEL_BIT]) ? fp_format_pkg::CLS_SIG_NAN : fp_format_pkg::CLS_QUIET_NAN;
  endfunction

  // Issue one request and note what the answer must hold
  task automatic run(input logic [2:0] op, input logic dbl, input logic [63:0] a, input logic [63:0] b,
                     input logic [63:0] d, input logic [63:0] m, input logic cm, input logic xm, input logic x);
    logic ok;
    host.issue(op, dbl, a, b, ok);
    exp_q.push_back('{d, m, cls_of(dbl, a), cm, x, xm, cyc});
    if (!ok) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic ctc(input logic [31:0] w);
    run(fp_format_pkg::OP_CTC, 1'b0, {32'h0, w}, 64'h0, 64'h0, 64'h0, 1'b0, 1'b0, 1'b0);
    csr_m = w & `CSR_WMASK;
  endtask
  // Wait for all answers, then let the mirrored control word settle
  task automatic end_test(input string name);
    int k;
    for (k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge clk);
    if (exp_q.size() > 0) begin
      num_errors++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk);
    chk_val("control word", {32'h0, csr_m}, {32'h0, csr & `CSR_WMASK});
    $display("test %s done", name);
  endtask

  // Answer watcher: one note per response pulse
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value response expected none seen one");
      end else begin
        cur = exp_q.pop_front();
        chk_val("latency", 64'(cur.t + 2), 64'(cyc));
        chk_val("data", cur.d & cur.m, rsp_data & cur.m);
        if (cur.cm) chk_cls(cur.c, rsp_class);
        if (cur.xm) chk_val("trap", {63'h0, cur.x}, {63'h0, rsp_exc});
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [63:0] a;
    logic [63:0] d;
    logic [63:0] s;
    int          i;
    int          n;
    int          sb;
    rst = 1'b1;
    void'($urandom(84539));
    repeat (3) @(posedge clk);
    chk_val("ready in reset", 64'h0, {63'h0, req_ready});
    rst <= 1'b0;
    @(posedge clk);
    #1 chk_val("ready after reset", 64'h1, {63'h0, req_ready});
    chk_val("control word reset", 64'h0, {32'h0, csr});
    // Classes in both NaN senses and both formats
    for (n = 0; n < 2; n++) begin
      ctc(n[0] ? 32'h00040000 : 32'h0);
      for (i = 0; i < 8; i++) begin
        run(fp_format_pkg::OP_CLASSIFY, 1'b0, {32'h0, pat_s[i]}, 64'h0, 64'h0, 64'h0, 1'b1, 1'b0, 1'b0);
        run(fp_format_pkg::OP_CLASSIFY, 1'b1, pat_d[i], 64'h0, 64'h0, 64'h0, 1'b1, 1'b0, 1'b0);
      end
    end
    end_test("classify");
    // Moves never trap; random normals check sign handling at both widths
    run(fp_format_pkg::OP_MOVE, 1'b0, 64'h7fffff, 64'h0, 64'h7fffff, M32, 1'b1, 1'b1, 1'b0);
    run(fp_format_pkg::OP_MOVE, 1'b1, 64'h800fffffffffffff, 64'h0, 64'h800fffffffffffff, ALL, 1'b1, 1'b1, 1'b0);
    for (i = 0; i < 42; i++) begin
      s = {$urandom, $urandom};
      sb = (i % 2) ? 63 : 31;
      a = (i % 2) ? {s[63], s[62:52] % 11'h7fe + 11'h1, s[51:0]} : {32'h0, s[31], s[30:23] % 8'hfe + 8'h1, s[22:0]};
      d = a;
      if (i % 3 == 1) d[sb] = 1'b0;
      if (i % 3 == 2) d[sb] = ~a[sb];
      run(sgn_ops[i % 3], 1'(i % 2), a, 64'h0, d, (i % 2) ? ALL : M32, 1'b1, 1'b1, 1'b0);
    end
    end_test("sign ops");
    // Denormal operand traps with zero data and leaves the writable control bits alone
    ctc(32'h0000007c);
    run(fp_format_pkg::OP_ABS, 1'b0, 64'h807fffff, 64'h0, 64'h0, ALL, 1'b1, 1'b1, 1'b1);
    run(fp_format_pkg::OP_NEG, 1'b1, 64'h000fffffffffffff, 64'h0, 64'h0, ALL, 1'b1, 1'b1, 1'b1);
    run(fp_format_pkg::OP_CFC, 1'b0, 64'h0, 64'h0, {32'h0, csr_m}, {32'h0, `CSR_WMASK}, 1'b0, 1'b0, 1'b0);
    end_test("trap");
    // With flush-to-zero, denormal operands to abs give zero without a trap
    ctc(32'h01000000);
    run(fp_format_pkg::OP_ABS, 1'b0, 64'h807fffff, 64'h0, 64'h0, M32, 1'b0, 1'b1, 1'b0);
    run(fp_format_pkg::OP_ABS, 1'b1, 64'h800fffffffffffff, 64'h0, 64'h0, ALL, 1'b0, 1'b1, 1'b0);
    end_test("flush");
    // Default quiet NaN per format and select; a quiet operand passes through
    for (n = 0; n < 4; n++) begin
      ctc(n[0] ? 32'h00040000 : 32'h0);
      a = n[1] ? 64'h3ff0000000000000 : 64'h3f800000;
      run(fp_format_pkg::OP_INVALID, n[1], a, 64'h0, qn[n], n[1] ? ALL : M32, 1'b0, 1'b1, 1'b0);
      a = n[1] ? (n[0] ? 64'h7ff8000000000001 : 64'h7ff4000000000001) : (n[0] ? 64'h7fc00001 : 64'h7fa00001);
      run(fp_format_pkg::OP_INVALID, n[1], a, 64'h0, a, n[1] ? ALL : M32, 1'b1, 1'b1, 1'b0);
    end
    ctc(32'h0);
    end_test("invalid");
    // Signed zeros compare equal; a signaling NaN is unequal and raises invalid
    run(fp_format_pkg::OP_CMP_EQ, 1'b0, 64'h80000000, 64'h0, 64'h0, 64'h0, 1'b1, 1'b1, 1'b0);
    csr_m = 32'h00800000;
    end_test("compare zero");
    run(fp_format_pkg::OP_CMP_EQ, 1'b1, 64'h7ff8000000000000, 64'h7ff8000000000000, 64'h0, 64'h0, 1'b1, 1'b1, 1'b0);
    csr_m = 32'h00000040;
    end_test("compare nan");
    tally_and_finish();
  end
endmodule
`default_nettype wire
